// file: include/scr_pkg.sv
/*
  Package of the system control register bank: transfer decode, control
  bit positions, identification fields, reset values and region decode.
  Assumes a core that issues single coprocessor register transfers.
*/
package scr_pkg;

  // register numbers (primary register field of a transfer)
  localparam logic [3:0]  SCR_REG_IDENTIFICATION_WORD   = 4'h0;  // identification_word
  localparam logic [3:0]  SCR_REG_CONTROL   = 4'h1;  // global_control
  localparam logic [3:0]  SCR_REG_TEST      = 4'hf;
  localparam logic [3:0]  SCR_CRM_ZERO      = 4'h0;
  localparam logic [2:0]  SCR_OP2_CONTROL   = 3'h0;
  localparam logic [2:0]  SCR_OP1_TEST      = 3'h1;
  localparam logic [2:0]  SCR_OP1_ZERO      = 3'h0;
  localparam logic [2:0]  SCR_OP2_TRACE_CTL = 3'h0;
  localparam logic [2:0]  SCR_OP2_BIST_CTL  = 3'h1;

  // global_control bit positions
  localparam int          SCR_CTL_LOAD_PC_DIS = 15;
  localparam int          SCR_CTL_VEC_HIGH    = 13;
  localparam int          SCR_CTL_ISRAM_EN    = 12;
  localparam int          SCR_CTL_BIG_END     = 7;
  localparam int          SCR_CTL_WBUF_EN     = 3;
  localparam int          SCR_CTL_DSRAM_EN    = 2;
  // only these bits hold state; all others read zero
  localparam logic [31:0] SCR_CTL_IMPL_MASK   = 32'h0000_b08c;
  localparam logic [31:0] SCR_CTL_RESET       = 32'h0000_0000;

  // trace control and bist control bits (register 15)
  localparam int          SCR_TRC_MASK_IRQ    = 1;
  localparam int          SCR_TRC_MASK_FIQ    = 2;
  localparam int          SCR_BIST_I_EN       = 18;
  localparam int          SCR_BIST_D_EN       = 2;

  // identification word fields, values arbitrary
  localparam logic [7:0]  SCR_ID_IMPLEMENTOR  = 8'h5a;
  localparam logic [3:0]  SCR_ID_VARIANT      = 4'h1;
  localparam logic [3:0]  SCR_ID_ARCH         = 4'h2;
  localparam logic [11:0] SCR_ID_PART         = 12'h3c4;
  localparam logic [3:0]  SCR_ID_VERSION      = 4'h1;

  // exception vector bases
  localparam logic [31:0] SCR_VEC_LOW         = 32'h0000_0000;
  localparam logic [31:0] SCR_VEC_HIGH        = 32'hffff_0000;

  // fixed memory regions: match when (addr & mask) == base
  localparam logic [31:0] SCR_IMEM_MASK       = 32'hf000_0000;
  localparam logic [31:0] SCR_IMEM_BASE       = 32'h0000_0000;
  localparam logic [31:0] SCR_DMEM_MASK       = 32'hf000_0000;
  localparam logic [31:0] SCR_DMEM_BASE       = 32'h4000_0000;
  localparam logic [31:0] SCR_BUFR_MASK       = 32'hf000_0000;
  localparam logic [31:0] SCR_BUFR_BASE       = 32'h6000_0000;

  // strap capture: clocks after reset release before sampling
  localparam logic [1:0]  SCR_STRAP_SETTLE    = 2'h3;
  localparam int          SCR_STRAP_W         = 2;

endpackage : scr_pkg

// file: rtl/scr_sync.sv
/*
  Three-stage synchroniser for slow level inputs such as straps.
  Assumes inputs change rarely; a change is accepted once stages two and
  three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module scr_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,  // core clock
  input  wire logic         rst,      // async reset, active high
  input  wire logic [W-1:0] async_in, // pins from outside the domain
  output logic      [W-1:0] sync_out, // accepted level
  output logic      [W-1:0] stable    // agreed level already in sync_out
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      logic out_nxt;
      always_comb begin
        out_nxt = (s2_r == s3_r) ? s3_r : out_r;
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          out_r <= 1'b0;
        end else begin
          s1_r  <= async_in[g];
          s2_r  <= s1_r;
          s3_r  <= s2_r;
          out_r <= out_nxt;
        end
      end
      assign sync_out[g] = out_r;
      // wait for out_r too, else a load at agreement takes the old level
      assign stable[g]   = (s2_r == s3_r) && (out_r == s3_r);
    end
  endgenerate

endmodule : scr_sync

`default_nettype wire

// file: rtl/scr_system_control.sv
/*
  System control coprocessor register bank: identification word, global
  control register, trace control and bist enables, plus the routing and
  buffering attributes that the control bits steer.
  Assumes the core presents one register transfer per valid pulse and that
  straps are steady around reset release.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] register 0 returns read-only identification word
// [R2] register 0 ignores the secondary opcode
// [R3] control register at c1, c0, opcode 0
// [R4] software preserves reserved bits on write
// [R5] reserved control bits may read anything
// [R6] bit 15 disables pc-load state change; resets 0
// [R7] bit 13 selects vector base low/high
// [R8] bit 13 loads from vector strap at reset
// [R9] bit 12 routes instruction region to sram
// [R10] bit 12 loads from sram strap at reset
// [R11] bit 7 big-endian when set; resets 0
// [R12] bit 3 enables buffered stores; resets 0
// [R13] already-buffered writes stay buffered after disable
// [R14] bit 2 routes data region to sram
// [R15] bit 2 loads from sram strap too
// [R16] register 15 decodes secondary opcode
// [R17] registers reached only by coprocessor transfers
// [R18] enabling sram bist clears its enable bit
// [R19] undescribed control bits ignore writes, read zero
module scr_system_control (
  input  wire logic                    ref_clk,               // core clock, 40 MHz
  input  wire logic                    rst,                   // async reset, active high
  input  wire logic                    cp_valid,              // transfer request pulse
  input  wire logic                    cp_write,              // 1 = write transfer, 0 = read
  input  wire logic [2:0]              cp_op1,                // primary opcode field
  input  wire logic [3:0]              cp_crn,                // primary register number
  input  wire logic [3:0]              cp_crm,                // secondary register number
  input  wire logic [2:0]              cp_op2,                // secondary opcode field
  input  wire logic [31:0]             cp_wdata,              // write data
  output logic      [31:0]             cp_rdata,              // read data
  output logic                         cp_done,               // transfer accepted pulse
  output logic                         cp_undef,              // transfer not decoded pulse
  input  wire logic                    vector_high_strap,     // vector location strap pin
  input  wire logic                    sram_enable_strap,     // sram enable strap pin
  output logic                         ctl_ready,             // straps loaded, transfers taken
  input  wire logic                    i_req,                 // instruction access request
  input  wire logic [31:0]             i_addr,                // instruction access address
  input  wire logic                    d_req,                 // data access request
  input  wire logic                    d_write,               // data access is a store
  input  wire logic [31:0]             d_addr,                // data access address
  output logic                         i_sel_sram,            // instruction access to sram
  output logic                         i_sel_bus,             // instruction access to system bus
  output logic                         d_sel_sram,            // data access to sram
  output logic                         d_sel_bus,             // data access to system bus
  output logic                         d_store_buffered,      // bus store tagged bufferable
  output logic                         load_pc_state_disable, // suppress pc-load state change
  output logic                         big_endian,            // endian select
  output logic                         write_buffer_enable,   // write buffer use
  output logic                         itcm_enable,           // instruction sram enable
  output logic                         dtcm_enable,           // data sram enable
  output logic      [31:0]             exc_vector_base,       // exception vector base
  output logic                         trace_mask_irq,        // mask irq during trace
  output logic                         trace_mask_fiq,        // mask fiq during trace
  output logic                         ibist_enable,          // instruction sram bist enable
  output logic                         dbist_enable           // data sram bist enable
);
  import scr_pkg::*;

  typedef enum logic {SCR_ST_STRAP, SCR_ST_RUN} scr_state_e;

  logic [SCR_STRAP_W-1:0] strap_lvl;
  logic [SCR_STRAP_W-1:0] strap_ok;

  scr_sync #(
    .W        (SCR_STRAP_W)
  ) u_strap_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({sram_enable_strap, vector_high_strap}),
    .sync_out (strap_lvl),
    .stable   (strap_ok)
  );

  scr_state_e  state_r;
  scr_state_e  state_nxt;
  logic [1:0]  settle_r;
  logic [1:0]  settle_nxt;
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  logic [2:0]  trc_r;
  logic [2:0]  trc_nxt;
  logic        ibist_r;
  logic        ibist_nxt;
  logic        dbist_r;
  logic        dbist_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        undef_r;
  logic        undef_nxt;
  logic        isram_r;
  logic        isram_nxt;
  logic        ibus_r;
  logic        ibus_nxt;
  logic        dsram_r;
  logic        dsram_nxt;
  logic        dbus_r;
  logic        dbus_nxt;
  logic        dbuf_r;
  logic        dbuf_nxt;
  logic [31:0] vec_r;
  logic [31:0] vec_nxt;

  logic        hit_id;
  logic        hit_ctl;
  logic        hit_trc;
  logic        hit_bist;
  logic [31:0] id_word;
  logic [31:0] bist_word;

  assign id_word = {SCR_ID_IMPLEMENTOR, SCR_ID_VARIANT, SCR_ID_ARCH, SCR_ID_PART, SCR_ID_VERSION}; // R1

  always_comb begin
    bist_word                = 32'h0000_0000;
    bist_word[SCR_BIST_I_EN] = ibist_r;
    bist_word[SCR_BIST_D_EN] = dbist_r;
  end

  // transfer decode; register 0 matches any secondary fields
  always_comb begin
    hit_id   = (cp_crn == SCR_REG_IDENTIFICATION_WORD) && (cp_op1 == SCR_OP1_ZERO); // R2
    hit_ctl  = (cp_crn == SCR_REG_CONTROL) && (cp_op1 == SCR_OP1_ZERO)
               && (cp_crm == SCR_CRM_ZERO) && (cp_op2 == SCR_OP2_CONTROL); // R3
    hit_trc  = (cp_crn == SCR_REG_TEST) && (cp_op1 == SCR_OP1_TEST)
               && (cp_op2 == SCR_OP2_TRACE_CTL); // R16
    hit_bist = (cp_crn == SCR_REG_TEST) && (cp_op1 == SCR_OP1_TEST)
               && (cp_op2 == SCR_OP2_BIST_CTL); // R16
  end

  // register state and transfer answers
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    ctl_nxt   = ctl_r;
    trc_nxt   = trc_r;
    ibist_nxt = ibist_r;
    dbist_nxt = dbist_r;
    rdata_nxt = rdata_r;
    done_nxt  = 1'b0;
    undef_nxt = 1'b0;
    case (state_r)
      SCR_ST_STRAP: begin
        // straps are sampled after release since async reset takes constants only
        if (settle_r != SCR_STRAP_SETTLE) begin
          settle_nxt = settle_r + 2'h1;
        end else if (&strap_ok) begin
          ctl_nxt[SCR_CTL_VEC_HIGH] = strap_lvl[0]; // R8
          ctl_nxt[SCR_CTL_ISRAM_EN] = strap_lvl[1]; // R10
          ctl_nxt[SCR_CTL_DSRAM_EN] = strap_lvl[1]; // R15
          state_nxt = SCR_ST_RUN;
        end
      end
      SCR_ST_RUN: begin
        // only coprocessor transfers touch the registers
        if (cp_valid) begin // R17
          done_nxt = 1'b1;
          if (cp_write) begin
            if (hit_ctl) begin
              // unimplemented bits dropped; software keeps them by read-modify-write
              ctl_nxt = cp_wdata & SCR_CTL_IMPL_MASK; // R19 R4
            end else if (hit_trc) begin
              trc_nxt = {cp_wdata[SCR_TRC_MASK_FIQ], cp_wdata[SCR_TRC_MASK_IRQ], 1'b0};
            end else if (hit_bist) begin
              ibist_nxt = cp_wdata[SCR_BIST_I_EN];
              dbist_nxt = cp_wdata[SCR_BIST_D_EN];
              // bist corrupts the sram, so stop it being used afterwards
              if (cp_wdata[SCR_BIST_I_EN]) begin
                ctl_nxt[SCR_CTL_ISRAM_EN] = 1'b0; // R18
              end
              if (cp_wdata[SCR_BIST_D_EN]) begin
                ctl_nxt[SCR_CTL_DSRAM_EN] = 1'b0; // R18
              end
            end else begin
              done_nxt  = 1'b0;
              undef_nxt = 1'b1;
            end
          end else begin
            if (hit_id) begin
              rdata_nxt = id_word; // R1 R2
            end else if (hit_ctl) begin
              rdata_nxt = ctl_r & SCR_CTL_IMPL_MASK; // R5 R19
            end else if (hit_trc) begin
              rdata_nxt = {29'h0000_0000, trc_r};
            end else if (hit_bist) begin
              rdata_nxt = bist_word;
            end else begin
              rdata_nxt = 32'h0000_0000;
              done_nxt  = 1'b0;
              undef_nxt = 1'b1;
            end
          end
        end
      end
      default: begin
        state_nxt = SCR_ST_STRAP;
      end
    endcase
  end

  // routing and store attributes, sampled per access
  always_comb begin
    isram_nxt = i_req && ctl_r[SCR_CTL_ISRAM_EN]
                && ((i_addr & SCR_IMEM_MASK) == SCR_IMEM_BASE); // R9
    ibus_nxt  = i_req && !isram_nxt; // R9
    dsram_nxt = d_req && ctl_r[SCR_CTL_DSRAM_EN]
                && ((d_addr & SCR_DMEM_MASK) == SCR_DMEM_BASE); // R14
    dbus_nxt  = d_req && !dsram_nxt; // R14
    // tagged at issue: a later disable leaves queued writes buffered
    dbuf_nxt  = dbus_nxt && d_write && ctl_r[SCR_CTL_WBUF_EN]
                && ((d_addr & SCR_BUFR_MASK) == SCR_BUFR_BASE); // R12 R13
    vec_nxt   = ctl_nxt[SCR_CTL_VEC_HIGH] ? SCR_VEC_HIGH : SCR_VEC_LOW; // R7
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r  <= SCR_ST_STRAP;
      settle_r <= 2'h0;
      ctl_r    <= SCR_CTL_RESET; // R6 R11 R12
      trc_r    <= 3'h0;
      ibist_r  <= 1'b0;
      dbist_r  <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      done_r   <= 1'b0;
      undef_r  <= 1'b0;
      isram_r  <= 1'b0;
      ibus_r   <= 1'b0;
      dsram_r  <= 1'b0;
      dbus_r   <= 1'b0;
      dbuf_r   <= 1'b0;
      vec_r    <= SCR_VEC_LOW;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      ctl_r    <= ctl_nxt;
      trc_r    <= trc_nxt;
      ibist_r  <= ibist_nxt;
      dbist_r  <= dbist_nxt;
      rdata_r  <= rdata_nxt;
      done_r   <= done_nxt;
      undef_r  <= undef_nxt;
      isram_r  <= isram_nxt;
      ibus_r   <= ibus_nxt;
      dsram_r  <= dsram_nxt;
      dbus_r   <= dbus_nxt;
      dbuf_r   <= dbuf_nxt;
      vec_r    <= vec_nxt;
    end
  end

  logic ready_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == SCR_ST_RUN);
    end
  end

  assign cp_rdata              = rdata_r;
  assign cp_done               = done_r;
  assign cp_undef              = undef_r;
  assign ctl_ready             = ready_r;
  assign i_sel_sram            = isram_r;
  assign i_sel_bus             = ibus_r;
  assign d_sel_sram            = dsram_r;
  assign d_sel_bus             = dbus_r;
  assign d_store_buffered      = dbuf_r;
  assign load_pc_state_disable = ctl_r[SCR_CTL_LOAD_PC_DIS]; // R6
  assign big_endian            = ctl_r[SCR_CTL_BIG_END]; // R11
  assign write_buffer_enable   = ctl_r[SCR_CTL_WBUF_EN]; // R12
  assign itcm_enable           = ctl_r[SCR_CTL_ISRAM_EN];
  assign dtcm_enable           = ctl_r[SCR_CTL_DSRAM_EN];
  assign exc_vector_base       = vec_r; // R7
  assign trace_mask_irq        = trc_r[SCR_TRC_MASK_IRQ];
  assign trace_mask_fiq        = trc_r[SCR_TRC_MASK_FIQ];
  assign ibist_enable          = ibist_r;
  assign dbist_enable          = dbist_r;

endmodule : scr_system_control

`default_nettype wire

// file: tb/scr_core_model.sv
/* Core model: issues one coprocessor register transfer at a time.
   Assumes the bench calls xfer from a single process. */
`timescale 1ns/1ps
`default_nettype none
module scr_core_model (
  input  wire logic        ref_clk,  // clock
  input  wire logic        cp_done,  // accepted
  input  wire logic        cp_undef, // not decoded
  input  wire logic [31:0] cp_rdata, // read data
  output logic             cp_valid, // request pulse
  output logic             cp_write, // write
  output logic      [2:0]  cp_op1,   // opcode 1
  output logic      [3:0]  cp_crn,   // register
  output logic      [3:0]  cp_crm,   // subregister
  output logic      [2:0]  cp_op2,   // opcode 2
  output logic      [31:0] cp_wdata  // write data
);
  initial begin
    cp_valid = 1'b0;
    {cp_write, cp_op1, cp_crn, cp_crm, cp_op2, cp_wdata} = '0;
  end
  // fields flipped after the pulse so a stale value never looks valid
  task automatic xfer(input logic [46:0] f, output logic [31:0] rd, output logic [1:0] st);
    @(negedge ref_clk);
    cp_valid = 1'b1;
    {cp_write, cp_op1, cp_crn, cp_crm, cp_op2, cp_wdata} = f;
    @(negedge ref_clk);
    cp_valid = 1'b0;
    {cp_write, cp_op1, cp_crn, cp_crm, cp_op2, cp_wdata} = ~f;
    rd = cp_rdata;
    st = {cp_done, cp_undef};
  endtask : xfer
endmodule : scr_core_model
`default_nettype wire

// file: tb/scr_system_control_asserts.sv
/* Checker of the system control register bank.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module scr_system_control_asserts
  import scr_pkg::*;
(
  input wire logic        ref_clk,               // clock
  input wire logic        rst,                   // reset
  input wire logic        cp_valid,              // request
  input wire logic        cp_write,              // write
  input wire logic [2:0]  cp_op1,                // opcode 1
  input wire logic [3:0]  cp_crn,                // register
  input wire logic [3:0]  cp_crm,                // subregister
  input wire logic [2:0]  cp_op2,                // opcode 2
  input wire logic [31:0] cp_wdata,              // write data
  input wire logic [31:0] cp_rdata,              // read data
  input wire logic        cp_done,               // accepted
  input wire logic        cp_undef,              // not decoded
  input wire logic        ctl_ready,             // straps loaded
  input wire logic        d_req,                 // data access
  input wire logic        d_write,               // store
  input wire logic [31:0] d_addr,                // data address
  input wire logic        d_sel_sram,            // to sram
  input wire logic        d_sel_bus,             // to bus
  input wire logic        d_store_buffered,      // bufferable
  input wire logic        big_endian,            // bit 7
  input wire logic        load_pc_state_disable, // bit 15
  input wire logic        write_buffer_enable,   // bit 3
  input wire logic        itcm_enable,           // bit 12
  input wire logic        dtcm_enable,           // bit 2
  input wire logic [31:0] exc_vector_base        // vectors
);
  default clocking dck @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk, rctl, wctl;
  assign tk   = cp_valid && ctl_ready;
  assign rctl = tk && cp_crn == 4'h1 && cp_op1 == 3'h0 && cp_crm == 4'h0 && cp_op2 == 3'h0;
  assign wctl = rctl && cp_write;
  AST_ID_READ: assert property (tk && !cp_write && cp_crn == 4'h0 && cp_op1 == 3'h0 |=> cp_done &&
    cp_rdata == {SCR_ID_IMPLEMENTOR, SCR_ID_VARIANT, SCR_ID_ARCH, SCR_ID_PART, SCR_ID_VERSION})
    else $error("id word wrong");
  AST_CTL_WRITE: assert property (wctl |=> cp_done && big_endian == $past(cp_wdata[7]) &&
    load_pc_state_disable == $past(cp_wdata[15])) else $error("control write lost");
  AST_VECTOR: assert property (wctl |=> exc_vector_base == ($past(cp_wdata[13]) ? SCR_VEC_HIGH : SCR_VEC_LOW))
    else $error("vector base wrong");
  AST_RSVD_READ: assert property (rctl && !cp_write |=> (cp_rdata & ~SCR_CTL_IMPL_MASK) == 32'h0)
    else $error("reserved bits set");
  AST_D_ROUTE: assert property (d_req |=> d_sel_sram == $past(dtcm_enable && d_addr[31:28] == 4'h4) &&
    d_sel_bus == !d_sel_sram) else $error("data route wrong");
  AST_BUFFERED: assert property (d_req && d_write |=>
    d_store_buffered == $past(write_buffer_enable && d_addr[31:28] == 4'h6)) else $error("buffer tag wrong");
  AST_HOLD: assert property (!wctl |=> $stable(big_endian) && $stable(write_buffer_enable))
    else $error("control changed without write");
  AST_REFUSED: assert property (cp_valid && !ctl_ready |=> !cp_done && !cp_undef)
    else $error("transfer taken early");
  AST_BIST_CLR: assert property (tk && cp_write && cp_crn == 4'hf && cp_op1 == 3'h1 && cp_op2 == 3'h1 &&
    cp_wdata[18] |=> !itcm_enable) else $error("sram enable kept");
endmodule : scr_system_control_asserts
bind scr_system_control scr_system_control_asserts chk_u (.*);
`default_nettype wire

// file: tb/system_control_registers_tb.sv
/* Bench of the system control register bank against a control model.
   Assumes the core model drives transfers and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module system_control_registers_tb;
  import scr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst, vector_high_strap, sram_enable_strap, i_req, d_req, d_write;
  logic [31:0] i_addr, d_addr, cp_wdata, cp_rdata, exc_vector_base, mctl, rd, wd;
  logic [2:0]  cp_op1, cp_op2;
  logic [3:0]  cp_crn, cp_crm;
  logic [1:0]  st;
  logic        cp_valid, cp_write, cp_done, cp_undef, ctl_ready, i_sel_sram, i_sel_bus, d_sel_sram, d_sel_bus;
  logic        d_store_buffered, load_pc_state_disable, big_endian, write_buffer_enable, itcm_enable;
  logic        dtcm_enable, trace_mask_irq, trace_mask_fiq, ibist_enable, dbist_enable;
  logic [3:0]  nib [4] = '{4'h0, 4'h4, 4'h6, 4'h9};
  int          mismatches = 0;
  int          compares = 0;

  always #12.5 ref_clk = ~ref_clk;
  scr_system_control dut_u (.*);
  scr_core_model core_u (.*);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic go(input logic [46:0] f);
    core_u.xfer(f, rd, st);
  endtask : go

  task automatic check_ctl();
    go({1'b0, 3'h0, 4'h1, 4'h0, 3'h0, 32'h0});
    chk("ctl done", st, 2'b10);
    chk("ctl read", rd, mctl);
    chk("ctl bits", {load_pc_state_disable, big_endian, write_buffer_enable}, {mctl[15], mctl[7], mctl[3]});
    chk("sram en", {itcm_enable, dtcm_enable}, {mctl[12], mctl[2]});
    chk("vector", exc_vector_base, mctl[13] ? SCR_VEC_HIGH : SCR_VEC_LOW);
  endtask : check_ctl

  // straps drawn fresh at each of the two boots, so a loaded bit sees both levels only if its two draws differ
  task automatic boot();
    rst = 1'b1;
    vector_high_strap = 1'($urandom);
    sram_enable_strap = 1'($urandom);
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    go({1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 32'h0000_0080});
    chk("early answer", st, 2'b00);
    for (int k = 0; k < 20 && ctl_ready !== 1'b1; k++) @(negedge ref_clk);
    chk("ready", ctl_ready, 1'b1);
    mctl = 32'(vector_high_strap) << 13 | 32'(sram_enable_strap) * 32'h0000_1004;
    check_ctl();
  endtask : boot

  task automatic route(input logic [31:0] ia, input logic [31:0] da, input logic wr);
    logic is, ds;
    {i_req, d_req, i_addr, d_addr, d_write} = {2'b11, ia, da, wr};
    @(negedge ref_clk);
    is = mctl[12] && ia[31:28] == 4'h0;
    ds = mctl[2] && da[31:28] == 4'h4;
    chk("i route", {i_sel_sram, i_sel_bus}, {is, !is});
    chk("d route", {d_sel_sram, d_sel_bus}, {ds, !ds});
    chk("bufferable", d_store_buffered, wr && mctl[3] && da[31:28] == 4'h6);
  endtask : route

  initial begin
    {i_req, d_req, d_write, i_addr, d_addr} = '0;
    void'($urandom(32'hfe4c795b));
    boot();
    for (int k = 0; k < 8; k++) begin
      go({1'b0, 3'h0, 4'h0, 4'($urandom), 3'(k), 32'h0});
      chk("id word", rd, {SCR_ID_IMPLEMENTOR, SCR_ID_VARIANT, SCR_ID_ARCH, SCR_ID_PART, SCR_ID_VERSION});
    end
    for (int k = 0; k < 12; k++) begin
      wd = (k == 0) ? 32'h0000_bfff : $urandom & 32'h0000_bfff;
      go({1'b1, 3'h0, 4'h1, 4'h0, 3'h0, wd});
      mctl = wd & SCR_CTL_IMPL_MASK;
      check_ctl();
      for (int j = 0; j < 4; j++) route({nib[$urandom % 4], 28'($urandom)}, {nib[j], 28'($urandom)}, 1'($urandom));
      {i_req, d_req} = 2'b00;
    end
    for (int n = 2; n < 16; n++) begin
      go({1'b1, 3'h0, 4'(n % 15), 4'h0, 3'h1, 32'h0000_ffff});
      chk("undecoded", st, 2'b01);
    end
    check_ctl();
    // store issued at the edge that turns buffering off keeps its tag
    go({1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 32'h0000_100c});
    {d_req, d_write, d_addr} = {2'b11, 32'h6000_0010};
    go({1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 32'h0000_1004});
    chk("drain tag", d_store_buffered, 1'b1);
    @(negedge ref_clk);
    chk("new tag", d_store_buffered, 1'b0);
    d_req = 1'b0;
    go({1'b1, 3'h1, 4'hf, 4'($urandom), 3'h0, 32'h0000_0006});
    chk("trace", {trace_mask_irq, trace_mask_fiq}, 2'b11);
    go({1'b1, 3'h1, 4'hf, 4'($urandom), 3'h1, 32'h0004_0004});
    chk("bist", {ibist_enable, dbist_enable}, 2'b11);
    go({1'b0, 3'h1, 4'hf, 4'h0, 3'h1, 32'h0});
    chk("bist read", rd, 32'h0004_0004);
    mctl = 32'h0;
    check_ctl();
    go({1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 32'h0000_8088});
    boot();
    wrap_up();
  end

  initial begin
    #(25 * 4000);
    mismatches++;
    wrap_up();
  end
endmodule : system_control_registers_tb
`default_nettype wire
